// >>> rtl/sfpu_seq.sv
// Purpose: Power-on state, SPI mode pick and internal busy timing
// Assumes: chip_select_n and sclk are async pins, op requests are local
// Notes: Long delays are parameters so a simulation can shorten them
// How it works
// [RL1] Data output stays undriven after power-up or reset until a command drives it.
// [RL2] A command is accepted only after a chip select fall seen since reset.
// [RL3] Each chip select fall picks mode 0 or 3 from the idle clock level.
// [RL4] While power-on reset is active nothing runs and commands are ignored.
// [RL5] The host waits 70 us after power-on before a read.
// [RL6] A first program or erase does not start until the 3 ms warm-up ends.
// [RL7] After warm-up the device is in standby or active by chip select level; the code shows neither while busy.
// [RL8] A page program keeps the device busy at most 2.5 ms.
// [RL9] A page erase keeps the device busy at most 20 ms.
// [RL10] An OTP program keeps the device busy 400 us typical, 950 us at most.
// [RL11] A status write keeps the device busy at most 200 ns.
// [RL12] The device shows busy for the whole of each internal operation.
`timescale 1ns/1ps
module sfpu_seq #(
  parameter int READ_DELAY = sfpu_pkg::READ_DELAY_CYC,
  parameter int PROGRAM_DELAY = sfpu_pkg::PROGRAM_DELAY_CYC,
  parameter int PAGE_PROGRAM = sfpu_pkg::PAGE_PROGRAM_CYC,
  parameter int PAGE_ERASE = sfpu_pkg::PAGE_ERASE_CYC,
  parameter int OTP_PROGRAM = sfpu_pkg::OTP_PROGRAM_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_active,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic [1:0] cmd_op,
  input wire logic out_drive_req,
  input wire logic out_data,
  output logic cmd_accept,
  output logic so_out,
  output logic so_oe,
  output logic spi_mode3,
  output logic busy,
  output logic read_ready,
  output logic standby,
  output logic active
);
  logic [1:0] cs_sync;
  logic [1:0] clk_sync;
  logic cs_prev;
  logic armed;
  logic frame_open;
  logic [sfpu_pkg::CNT_W-1:0] warm_cnt;
  logic [sfpu_pkg::CNT_W-1:0] op_cnt;
  logic read_ok;
  sfpu_pkg::sfpu_state_t state;
  logic cs_fall;
  logic is_write;
  logic take;

  function automatic logic [sfpu_pkg::CNT_W-1:0] op_len(
      input logic [1:0] op);
    unique case (op)
      sfpu_pkg::SFPU_OP_PAGE_PROGRAM: op_len = sfpu_pkg::CNT_W'(PAGE_PROGRAM);
      sfpu_pkg::SFPU_OP_PAGE_ERASE: op_len = sfpu_pkg::CNT_W'(PAGE_ERASE);
      sfpu_pkg::SFPU_OP_OTP_PROGRAM: op_len = sfpu_pkg::CNT_W'(OTP_PROGRAM);
      sfpu_pkg::SFPU_OP_STATUS_WRITE:
        op_len = sfpu_pkg::CNT_W'(sfpu_pkg::STATUS_WRITE_CYC);
    endcase
  endfunction : op_len

  // Pins pass two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_sync <= 2'h3;
      clk_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[0], chip_select_n};
      clk_sync <= {clk_sync[0], sclk};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) cs_prev <= 1'h1;
    else cs_prev <= cs_sync[1];
  end

  assign cs_fall = cs_prev && !cs_sync[1];

  // Mode latched from idle clock at each select fall
  always_ff @(posedge clk) begin
    if (!rst_n) spi_mode3 <= sfpu_pkg::MODE_RESET;
    else if (cs_fall) spi_mode3 <= clk_sync[1]; // [RL3]
  end

  // Commands need a select fall seen after reset
  always_ff @(posedge clk) begin
    if (!rst_n || por_active) begin
      armed <= 1'h0;
      frame_open <= 1'h0;
    end else begin
      if (cs_fall) armed <= 1'h1; // [RL2]
      if (cs_fall) frame_open <= 1'h1;
      else if (cs_sync[1]) frame_open <= 1'h0;
    end
  end

  assign is_write = !cmd_is_read;
  assign take = cmd_valid && armed && frame_open && !por_active
      && (state == sfpu_pkg::SFPU_ST_READY
          || (state == sfpu_pkg::SFPU_ST_WARMUP && cmd_is_read
              && read_ok)); // [RL2] [RL4] [RL6]
  assign cmd_accept = take;

  // Warm-up counter; reads open early, writes wait the full delay
  always_ff @(posedge clk) begin
    if (!rst_n || por_active) begin
      warm_cnt <= '0;
      read_ok <= 1'h0;
    end else if (state == sfpu_pkg::SFPU_ST_WARMUP) begin
      warm_cnt <= warm_cnt + 1'b1;
      if (warm_cnt >= sfpu_pkg::CNT_W'(READ_DELAY - 1)) read_ok <= 1'h1; // [RL5]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || por_active) begin
      state <= sfpu_pkg::SFPU_ST_POR; // [RL4]
      op_cnt <= '0;
    end else begin
      unique case (state)
        sfpu_pkg::SFPU_ST_POR: state <= sfpu_pkg::SFPU_ST_WARMUP;
        sfpu_pkg::SFPU_ST_WARMUP:
          if (warm_cnt == sfpu_pkg::CNT_W'(PROGRAM_DELAY - 1))
            state <= sfpu_pkg::SFPU_ST_READY; // [RL6]
        sfpu_pkg::SFPU_ST_READY:
          if (take && is_write) begin
            state <= sfpu_pkg::SFPU_ST_BUSY; // [RL12]
            op_cnt <= op_len(cmd_op) - 1'b1; // [RL8] [RL9] [RL10] [RL11]
          end
        sfpu_pkg::SFPU_ST_BUSY:
          if (op_cnt == '0) state <= sfpu_pkg::SFPU_ST_READY;
          else op_cnt <= op_cnt - 1'b1;
      endcase
    end
  end

  assign busy = (state == sfpu_pkg::SFPU_ST_BUSY); // [RL12]
  assign read_ready = read_ok;
  assign standby = (state == sfpu_pkg::SFPU_ST_READY) && cs_sync[1]; // [RL7]
  assign active = (state == sfpu_pkg::SFPU_ST_READY) && !cs_sync[1]; // [RL7]

  // Output undriven until a command in an open frame asks for it
  always_ff @(posedge clk) begin
    if (!rst_n || por_active) begin
      so_oe <= 1'h0; // [RL1]
      so_out <= 1'h0;
    end else begin
      so_oe <= out_drive_req && frame_open && !cs_sync[1]; // [RL1]
      so_out <= out_data;
    end
  end

  // Busy watch; the limit comes from the command that started it
  logic [sfpu_pkg::CNT_W-1:0] busy_run;
  logic [sfpu_pkg::CNT_W-1:0] busy_lim;
  logic [1:0] busy_op;
  logic start_op;

  assign start_op = take && is_write && (state == sfpu_pkg::SFPU_ST_READY);

  always_ff @(posedge clk) begin
    if (!rst_n || por_active) begin
      busy_run <= '0;
    end else if (busy) begin
      busy_run <= busy_run + 1'b1;
    end else begin
      busy_run <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || por_active) begin
      busy_lim <= '0;
      busy_op <= 2'h0;
    end else if (start_op) begin
      busy_lim <= op_len(cmd_op);
      busy_op <= cmd_op;
    end
  end

  no_early_write_a: assert property ( // [RL6]
    @(posedge clk) disable iff (!rst_n)
    (state == sfpu_pkg::SFPU_ST_WARMUP) |-> !(cmd_accept && !cmd_is_read))
    else $error("write accepted during warm-up");

  idle_so_a: assert property ( // [RL1]
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> !so_oe)
    else $error("output driven after reset");

  armed_cmd_a: assert property ( // [RL2]
    @(posedge clk) disable iff (!rst_n)
    cmd_accept |-> armed)
    else $error("command taken before select fall");

  mode_pick_a: assert property ( // [RL3]
    @(posedge clk) disable iff (!rst_n)
    cs_fall |=> spi_mode3 == $past(clk_sync[1]))
    else $error("mode not from idle clock");

  por_hold_a: assert property ( // [RL4]
    @(posedge clk) disable iff (!rst_n)
    por_active |-> !cmd_accept)
    else $error("command taken during power-on reset");

  status_busy_a: assert property ( // [RL11]
    @(posedge clk) disable iff (!rst_n)
    (cmd_accept && !cmd_is_read && state == sfpu_pkg::SFPU_ST_READY
     && cmd_op == 2'h3 && !por_active) |=> busy [*8] ##[1:30] !busy)
    else $error("status write busy time wrong");

  busy_start_a: assert property ( // [RL12]
    @(posedge clk) disable iff (!rst_n)
    (cmd_accept && !cmd_is_read && !por_active) |=> busy)
    else $error("busy not raised for operation");

  ready_state_a: assert property ( // [RL7]
    @(posedge clk) disable iff (!rst_n)
    (standby || active) |-> !busy && read_ok)
    else $error("standby or active before warm-up ends");

  read_gate_a: assert property ( // [RL5]
    @(posedge clk) disable iff (!rst_n)
    (cmd_accept && cmd_is_read) |-> read_ok)
    else $error("read taken before read delay");

  read_rise_a: assert property ( // [RL5]
    @(posedge clk) disable iff (!rst_n)
    $rose(read_ready) |-> warm_cnt == sfpu_pkg::CNT_W'(READ_DELAY))
    else $error("read ready at wrong time");

  warm_write_a: assert property ( // [RL6]
    @(posedge clk) disable iff (!rst_n)
    (state != sfpu_pkg::SFPU_ST_READY) |-> !(cmd_accept && !cmd_is_read))
    else $error("write taken outside ready");

  // Catches a ready state reached before the full warm-up count
  ready_warm_a: assert property ( // [RL7]
    @(posedge clk) disable iff (!rst_n)
    (standby || active) |-> warm_cnt == sfpu_pkg::CNT_W'(PROGRAM_DELAY))
    else $error("ready before warm-up delay");

  por_quiet_a: assert property ( // [RL4]
    @(posedge clk) disable iff (!rst_n)
    por_active |=> !busy && !so_oe && !read_ready && !standby && !active)
    else $error("activity during power-on reset");

  fall_arm_a: assert property ( // [RL2]
    @(posedge clk) disable iff (!rst_n)
    (cs_fall && !por_active) |=> armed)
    else $error("select fall did not arm");

  frame_close_a: assert property ( // [RL2]
    @(posedge clk) disable iff (!rst_n)
    cs_sync[1] |=> !frame_open)
    else $error("frame open with select high");

  mode_keep_a: assert property ( // [RL3]
    @(posedge clk) disable iff (!rst_n)
    !cs_fall |=> $stable(spi_mode3))
    else $error("mode changed without select fall");

  so_gate_a: assert property ( // [RL1]
    @(posedge clk) disable iff (!rst_n)
    !frame_open |=> !so_oe)
    else $error("output driven outside frame");

  so_drive_a: assert property ( // [RL1]
    @(posedge clk) disable iff (!rst_n)
    (out_drive_req && frame_open && !cs_sync[1] && !por_active)
      |=> so_oe && so_out == $past(out_data))
    else $error("output not driven on request");

  busy_block_a: assert property ( // [RL12]
    @(posedge clk) disable iff (!rst_n)
    busy |-> !cmd_accept)
    else $error("command taken while busy");

  busy_hold_a: assert property ( // [RL12]
    @(posedge clk) disable iff (!rst_n)
    (busy && !por_active && busy_run < busy_lim - 1'b1) |=> busy)
    else $error("busy dropped early");

  busy_exact_a: assert property ( // [RL12]
    @(posedge clk) disable iff (!rst_n)
    (busy && !por_active && busy_run == busy_lim - 1'b1) |=> !busy)
    else $error("busy held too long");

  page_prog_a: assert property ( // [RL8]
    @(posedge clk) disable iff (!rst_n)
    (busy && busy_op == sfpu_pkg::SFPU_OP_PAGE_PROGRAM)
      |-> busy_run < sfpu_pkg::CNT_W'(PAGE_PROGRAM))
    else $error("page program busy too long");

  page_erase_a: assert property ( // [RL9]
    @(posedge clk) disable iff (!rst_n)
    (busy && busy_op == sfpu_pkg::SFPU_OP_PAGE_ERASE)
      |-> busy_run < sfpu_pkg::CNT_W'(PAGE_ERASE))
    else $error("page erase busy too long");

  otp_prog_a: assert property ( // [RL10]
    @(posedge clk) disable iff (!rst_n)
    (busy && busy_op == sfpu_pkg::SFPU_OP_OTP_PROGRAM)
      |-> busy_run < sfpu_pkg::CNT_W'(OTP_PROGRAM))
    else $error("OTP program busy too long");

  status_wr_a: assert property ( // [RL11]
    @(posedge clk) disable iff (!rst_n)
    (busy && busy_op == sfpu_pkg::SFPU_OP_STATUS_WRITE)
      |-> busy_run < sfpu_pkg::CNT_W'(sfpu_pkg::STATUS_WRITE_CYC))
    else $error("status write busy too long");
endmodule : sfpu_seq

// >>> rtl/sfpu_pkg.sv
// Purpose: Constants for the flash power-up and busy-time sequencer
// Assumes: 125 MHz core clock
// Notes: Times held in their printed unit, cycles derived from them
package sfpu_pkg;
  localparam int CLK_MHZ = 125;
  localparam int POWER_TO_READ_DELAY_US = 70;
  localparam int POWER_TO_PROGRAM_DELAY_MS = 3;
  localparam int PAGE_PROGRAM_DURATION_US = 2500;
  localparam int PAGE_ERASE_DURATION_MS = 20;
  localparam int OTP_PROGRAM_DURATION_US = 950;
  localparam int OTP_PROGRAM_TYPICAL_US = 400;
  localparam int STATUS_WRITE_DURATION_NS = 200;
  localparam int PAGE_BYTES = 256;
  localparam int READ_DELAY_CYC = POWER_TO_READ_DELAY_US * CLK_MHZ;
  localparam int PROGRAM_DELAY_CYC = POWER_TO_PROGRAM_DELAY_MS * 1000 * CLK_MHZ;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_DURATION_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYC = PAGE_ERASE_DURATION_MS * 1000 * CLK_MHZ;
  localparam int OTP_PROGRAM_CYC = OTP_PROGRAM_TYPICAL_US * CLK_MHZ;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_DURATION_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 22;
  localparam logic MODE_RESET = 1'h0;
  typedef enum logic [1:0] {
    SFPU_OP_PAGE_PROGRAM = 2'h0,
    SFPU_OP_PAGE_ERASE = 2'h1,
    SFPU_OP_OTP_PROGRAM = 2'h2,
    SFPU_OP_STATUS_WRITE = 2'h3
  } sfpu_op_t;
  typedef enum logic [1:0] {
    SFPU_ST_POR = 2'h0,
    SFPU_ST_WARMUP = 2'h1,
    SFPU_ST_READY = 2'h3,
    SFPU_ST_BUSY = 2'h2
  } sfpu_state_t;
endpackage : sfpu_pkg

// >>> tb/sfpu_host.sv
// Purpose: SPI host stand-in driving select and serial clock
// Assumes: bench frame level opens and closes a frame
// Notes: Clock idles at the mode level outside frames
`timescale 1ns/1ps
module sfpu_host (
  input wire logic frame,
  input wire logic mode3,
  output logic chip_select_n,
  output logic sclk
);
  logic run;
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    run = 1'b0;
  end
  // Idle level settles first so the mode pick never sees an edge
  always @(posedge frame) begin
    sclk = mode3;
    #64 chip_select_n = 1'b0;
    #64 run = 1'b1;
  end
  always @(negedge frame) begin
    run = 1'b0;
    sclk = mode3;
    #32 chip_select_n = 1'b1;
  end
  always #32 if (run) sclk = ~sclk;
endmodule : sfpu_host

// >>> tb/spi_flash_power_up_and_op_timing_tb.sv
// Purpose: Self-checking bench for the power-up sequencer
// Assumes: shortened delays, busy lengths in core cycles
// Notes: Busy lengths are checked by a watcher through a queue
`timescale 1ns/1ps
module spi_flash_power_up_and_op_timing_tb;
  logic clk, rst_n, por_active, chip_select_n, sclk, cmd_valid, frame, mode3;
  logic cmd_accept, so_out, so_oe, spi_mode3, busy, read_ready, standby, active;
  logic [1:0] cmd_op;
  logic cmd_is_read, drv, dat;
  int errors = 0, cmd_count = 0, cmp_count = 0, n = 0;
  int lens[4] = '{40, 60, 30, 25};
  int q[$];
  sfpu_seq #(.READ_DELAY(20), .PROGRAM_DELAY(50), .PAGE_PROGRAM(40),
    .PAGE_ERASE(60), .OTP_PROGRAM(30)) uut (.clk(clk), .rst_n(rst_n),
    .por_active(por_active), .chip_select_n(chip_select_n), .sclk(sclk),
    .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read), .cmd_op(cmd_op),
    .out_drive_req(drv), .out_data(dat), .cmd_accept(cmd_accept),
    .so_out(so_out), .so_oe(so_oe), .spi_mode3(spi_mode3), .busy(busy),
    .read_ready(read_ready), .standby(standby), .active(active));
  sfpu_host u_host (.frame(frame), .mode3(mode3),
    .chip_select_n(chip_select_n), .sclk(sclk));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // Accept is combinational, so look before the taking edge
  task automatic issue(input logic rd, input logic [1:0] op, input logic exp);
    cmd_valid = 1'b1;
    cmd_is_read = rd;
    cmd_op = op;
    #2 chk(cmd_accept, exp, "accept");
    if (exp && !rd) q.push_back(lens[op]);
    cyc(1);
    cmd_valid = 1'b0;
  endtask : issue
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200 && busy !== 1'b0; i++) cyc(1);
    if (i == 200) begin
      errors++;
      $display("mismatch at %0t: busy hang", $time);
      report_and_stop();
    end
  endtask : wait_idle
  always @(posedge clk) begin
    if (busy === 1'b1) n++;
    else if (n > 0) begin
      cmp_count++;
      if (q.size() == 0 || q.pop_front() != n) begin
        errors++;
        $display("mismatch at %0t: busy length %0d", $time, n);
      end
      n = 0;
    end
  end
  initial begin
    {rst_n, por_active, cmd_valid, cmd_is_read, frame, mode3, drv, dat} = '0;
    cmd_op = 2'h0;
    void'($urandom(32'h463F));
    cyc(3);
    rst_n = 1'b1;
    chk(so_oe, 1'b0, "output driven");
    issue(1'b0, 2'h3, 1'b0);
    mode3 = 1'($urandom % 2);
    frame = 1'b1;
    cyc(30);
    chk(spi_mode3, mode3, "mode pick");
    issue(1'b0, 2'h0, 1'b0);
    chk(read_ready, 1'b1, "read ready");
    issue(1'b1, 2'h0, 1'b1);
    cyc(30);
    chk(active, 1'b1, "active");
    drv = 1'b1;
    dat = 1'($urandom % 2);
    cyc(1);
    chk(so_oe, 1'b1, "output enable");
    chk(so_out, dat, "output data");
    drv = 1'b0;
    cyc(1);
    chk(so_oe, 1'b0, "output release");
    for (int op = 0; op < 4; op++) begin
      issue(1'b0, 2'(op), 1'b1);
      cyc(1);
      issue(1'b0, 2'(op), 1'b0);
      wait_idle();
      cyc(2);
    end
    frame = 1'b0;
    cyc(20);
    chk(standby, 1'b1, "standby");
    drv = 1'b1;
    cyc(1);
    chk(so_oe, 1'b0, "output driven deselected");
    drv = 1'b0;
    por_active = 1'b1;
    issue(1'b0, 2'h3, 1'b0);
    chk(busy, 1'b0, "busy in reset");
    por_active = 1'b0;
    cyc(2);
    chk(read_ready, 1'b0, "read ready after reset");
    issue(1'b1, 2'h0, 1'b0);
    cyc(5);
    chk(q.size() == 0, 1'b1, "busy notes left");
    report_and_stop();
  end
endmodule : spi_flash_power_up_and_op_timing_tb
